// *** core/esi_status_irq.v ***
// Operation
// [R1] status bit 7 shows any interrupt pending
// [R2] buffer error sets sticky until host clears
// [R3] late collision sets sticky error bit 4
// [R4] status bit 2 follows receive activity
// [R5] transmit abort sets sticky bit 1
// [R6] clock ready set after timer expires
// [R7] clock ready cleared only by power-on
// [R8] global enable off holds pin high
// [R9] six per-source enables gate their sources
// [R10] enabled flagged source asserts pending, pin low
// [R11] flags set regardless of enable bits
// [R12] pin stays low until cleared or masked
// [R13] host clears flags by bit-field clear
// [R14] errors clear only by host; bits 5,3 zero (soft reset and power-on also clear the error bits)
// [R15] power-on zeroes both registers
`timescale 1ns/1ps
`include "esi_defs.vh"

// one sticky error bit: set wins over a clear in the same cycle
module esi_sticky_bit (
  // clock and resets
  input  wire clk_i,
  input  wire reset_n_i,
  input  wire soft_reset_i,
  // set and clear requests
  input  wire set_i,
  input  wire clr_i,
  // stored flag
  output wire flag_o
);

  reg  flag_r;
  reg  flag_nxt;

  // set checked first so an event is never lost to a clear
  always @* begin
    flag_nxt = flag_r;
    if (set_i) begin
      flag_nxt = 1'b1;
    end else if (clr_i) begin
      flag_nxt = 1'b0;
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_r <= 1'b0;
    end else if (soft_reset_i) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_o = flag_r;

endmodule // esi_sticky_bit

module esi_status_irq (
  // clock and resets
  input  wire       clk_i,
  input  wire       reset_n_i,
  input  wire       soft_reset_i,
  // command port register access
  input  wire       reg_req_i,
  input  wire       reg_sel_i,
  input  wire [1:0] reg_op_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  // source conditions
  input  wire       buffer_error_i,
  input  wire       late_collision_i,
  input  wire       receive_active_i,
  input  wire       transmit_abort_i,
  input  wire       oscillator_start_timer_done_i,
  input  wire       phy_ready_i,
  // interrupt flags from the flag register
  input  wire [7:0] interrupt_flags_i,
  // interrupt pin and summary
  output wire       irq_n_o,
  output wire       irq_pending_o,
  output wire [7:0] interrupt_enable_o
);

  // register state and next values
  reg  [7:0] interrupt_enable_r;
  reg  [7:0] interrupt_enable_nxt;
  reg        receive_active_r;
  reg        receive_active_nxt;
  reg        clock_ready_r;
  reg        clock_ready_nxt;
  reg  [7:0] reg_rdata_nxt;
  reg  [7:0] clr_bits;

  // command decode
  wire       op_write_w;
  wire       op_bit_set_w;
  wire       op_bit_clear_w;
  wire       wr_status_w;
  wire       wr_enable_w;

  // sticky error flags
  wire       buffer_error_w;
  wire       late_collision_error_w;
  wire       transmit_abort_error_w;

  // gated interrupt sources
  wire       src_packet_w;
  wire       src_dma_w;
  wire       src_link_w;
  wire       src_tx_done_w;
  wire       src_tx_err_w;
  wire       src_rx_err_w;
  wire [7:0] src_mask_w;
  wire       global_irq_enable_w;

  // assembled status byte
  wire [7:0] status_w;

  // command decode
  assign op_write_w     = (reg_op_i == `ESI_OP_WRITE);
  assign op_bit_set_w   = (reg_op_i == `ESI_OP_BIT_SET);
  assign op_bit_clear_w = (reg_op_i == `ESI_OP_BIT_CLEAR);
  assign wr_status_w    = reg_req_i && (reg_sel_i == `ESI_SEL_STATUS);
  assign wr_enable_w    = reg_req_i && (reg_sel_i == `ESI_SEL_ENABLE);

  // [R13] bit-field clear or written zero
  always @* begin
    clr_bits = 8'h00;
    if (wr_status_w) begin
      if (op_bit_clear_w) begin
        clr_bits = reg_wdata_i & `ESI_ST_CLEARABLE;
      end else if (op_write_w) begin
        clr_bits = ~reg_wdata_i & `ESI_ST_CLEARABLE;
      end
    end
  end

  // [R9] enable update, bit 2 kept zero
  always @* begin
    interrupt_enable_nxt = interrupt_enable_r;
    if (wr_enable_w) begin
      case (reg_op_i)
        `ESI_OP_WRITE: begin
          interrupt_enable_nxt = reg_wdata_i & `ESI_IE_WMASK;
        end
        `ESI_OP_BIT_SET: begin
          interrupt_enable_nxt = interrupt_enable_r | (reg_wdata_i & `ESI_IE_WMASK);
        end
        `ESI_OP_BIT_CLEAR: begin
          interrupt_enable_nxt = interrupt_enable_r & ~reg_wdata_i;
        end
        default: begin
          interrupt_enable_nxt = interrupt_enable_r;
        end
      endcase
    end
  end

  // [R15] enables zero on power-on
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interrupt_enable_r <= `ESI_IE_RESET;
    end else if (soft_reset_i) begin
      interrupt_enable_r <= `ESI_IE_RESET;
    end else begin
      interrupt_enable_r <= interrupt_enable_nxt;
    end
  end

  assign interrupt_enable_o  = interrupt_enable_r;
  assign global_irq_enable_w = interrupt_enable_r[`ESI_IE_GLOBAL];

  // [R11] flags taken regardless of enables
  // flag bit positions match enable bit positions
  // [R9] each enable gates its source
  assign src_packet_w  = interrupt_enable_r[`ESI_IE_PACKET] &
                         interrupt_flags_i[`ESI_IE_PACKET];
  assign src_dma_w     = interrupt_enable_r[`ESI_IE_DMA] &
                         interrupt_flags_i[`ESI_IE_DMA];
  assign src_link_w    = interrupt_enable_r[`ESI_IE_LINK] &
                         interrupt_flags_i[`ESI_IE_LINK];
  assign src_tx_done_w = interrupt_enable_r[`ESI_IE_TX_DONE] &
                         interrupt_flags_i[`ESI_IE_TX_DONE];
  assign src_tx_err_w  = interrupt_enable_r[`ESI_IE_TX_ERR] &
                         interrupt_flags_i[`ESI_IE_TX_ERR];
  assign src_rx_err_w  = interrupt_enable_r[`ESI_IE_RX_ERR] &
                         interrupt_flags_i[`ESI_IE_RX_ERR];

  // global bit and reserved bit 2 are not sources
  assign src_mask_w = {1'b0,
                       src_packet_w,
                       src_dma_w,
                       src_link_w,
                       src_tx_done_w,
                       1'b0,
                       src_tx_err_w,
                       src_rx_err_w};

  // [R10] summary of enabled flagged sources
  assign irq_pending_o = |src_mask_w;

  // [R8] [R12] pin low while gated cause remains
  assign irq_n_o = !(global_irq_enable_w && irq_pending_o);

  // [R2] [R14] buffer overrun or underrun
  esi_sticky_bit buffer_error_inst (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .soft_reset_i (soft_reset_i),
    .set_i        (buffer_error_i),
    .clr_i        (clr_bits[`ESI_ST_BUFFER_ERR]),
    .flag_o       (buffer_error_w)
  );

  // [R3] [R14] collision past 64 bytes
  esi_sticky_bit late_collision_inst (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .soft_reset_i (soft_reset_i),
    .set_i        (late_collision_i),
    .clr_i        (clr_bits[`ESI_ST_LATE_COL]),
    .flag_o       (late_collision_error_w)
  );

  // [R5] [R14] transmit request aborted
  esi_sticky_bit transmit_abort_inst (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .soft_reset_i (soft_reset_i),
    .set_i        (transmit_abort_i),
    .clr_i        (clr_bits[`ESI_ST_TX_ABORT]),
    .flag_o       (transmit_abort_error_w)
  );

  // [R4] follows receive activity
  always @* begin
    receive_active_nxt = receive_active_i;
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      receive_active_r <= 1'b0;
    end else if (soft_reset_i) begin
      receive_active_r <= 1'b0;
    end else begin
      receive_active_r <= receive_active_nxt;
    end
  end

  // [R6] set once timer done and phy ready
  always @* begin
    clock_ready_nxt = clock_ready_r;
    if (oscillator_start_timer_done_i && phy_ready_i) begin
      clock_ready_nxt = 1'b1;
    end
  end

  // [R7] soft reset leaves clock ready alone
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clock_ready_r <= 1'b0;
    end else begin
      clock_ready_r <= clock_ready_nxt;
    end
  end

  // [R1] pending summary in bit 7
  assign status_w[`ESI_ST_PENDING]     = irq_pending_o;
  assign status_w[`ESI_ST_BUFFER_ERR]  = buffer_error_w;
  // [R14] bits 5 and 3 read zero
  assign status_w[5]                   = 1'b0;
  assign status_w[`ESI_ST_LATE_COL]    = late_collision_error_w;
  assign status_w[3]                   = 1'b0;
  assign status_w[`ESI_ST_RX_ACTIVE]   = receive_active_r;
  assign status_w[`ESI_ST_TX_ABORT]    = transmit_abort_error_w;
  assign status_w[`ESI_ST_CLOCK_READY] = clock_ready_r;

  // read data captured on every request
  always @* begin
    reg_rdata_nxt = reg_rdata_o;
    if (reg_req_i) begin
      if (reg_sel_i == `ESI_SEL_ENABLE) begin
        reg_rdata_nxt = interrupt_enable_r;
      end else begin
        reg_rdata_nxt = status_w;
      end
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rdata_nxt;
    end
  end

  // bit set on status has no effect
  // op_bit_set_w is unused; the enable register decodes bit set in its own case

endmodule // esi_status_irq

// *** shared/esi_defs.vh ***
`ifndef ESI_DEFS_VH
`define ESI_DEFS_VH

// register select codes on the command port
`define ESI_SEL_STATUS      1'b0
`define ESI_SEL_ENABLE      1'b1

// ethernet_status bit positions
`define ESI_ST_PENDING      7
`define ESI_ST_BUFFER_ERR   6
`define ESI_ST_LATE_COL     4
`define ESI_ST_RX_ACTIVE    2
`define ESI_ST_TX_ABORT     1
`define ESI_ST_CLOCK_READY  0

// interrupt_enable bit positions
`define ESI_IE_GLOBAL       7
`define ESI_IE_PACKET       6
`define ESI_IE_DMA          5
`define ESI_IE_LINK         4
`define ESI_IE_TX_DONE      3
`define ESI_IE_TX_ERR       1
`define ESI_IE_RX_ERR       0

// writable bits and reset value of interrupt_enable, clearable ethernet_status bits
`define ESI_IE_WMASK        8'hfb
`define ESI_IE_RESET        8'h00
`define ESI_ST_CLEARABLE    8'h52

// command port operations
`define ESI_OP_WRITE        2'h1
`define ESI_OP_BIT_SET      2'h2
`define ESI_OP_BIT_CLEAR    2'h3

`endif

// *** verif/esi_host.sv ***
`timescale 1ns/1ps
module esi_host (
  input  wire        clk_i,
  output logic       req_o = 1'h0,
  output logic       sel_o = 1'h0,
  output logic [1:0] op_o = 2'h0,
  output logic [7:0] wd_o = 8'h00
);
  task automatic cmd(logic s, logic [1:0] o, logic [7:0] d);
    @(posedge clk_i) #1 {req_o, sel_o, op_o, wd_o} = {1'b1, s, o, d};
    @(posedge clk_i) #1 {req_o, wd_o} = {1'b0, ~d};
  endtask
endmodule // esi_host

// *** verif/esi_chk_asserts.sv ***
`timescale 1ns/1ps
module esi_chk (
  input wire clk_i, reset_n_i, soft_reset_i, reg_req_i, reg_sel_i, irq_n_o, irq_pending_o,
  input wire buffer_error_i, late_collision_i, transmit_abort_i, receive_active_i,
  input wire oscillator_start_timer_done_i, phy_ready_i,
  input wire [1:0] reg_op_i,
  input wire [7:0] reg_wdata_i, reg_rdata_o, interrupt_flags_i, interrupt_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire [7:0] ie = interrupt_enable_o, q = reg_rdata_o;
  wire [7:0] hit = interrupt_flags_i & ie & 8'h7b;
  wire rd = reg_req_i & !reg_sel_i & reg_op_i == 2'h0;
  wire se = buffer_error_i && late_collision_i && transmit_abort_i;
  a_pend_sum: assert property (irq_pending_o == |hit) else $error("pend");
  a_pin_gate: assert property (irq_n_o == !(ie[7] && |hit)) else $error("pin");
  a_ie_write: assert property (reg_req_i && reg_sel_i && reg_op_i == 2'h1 && !soft_reset_i
    |=> ie == ($past(reg_wdata_i) & 8'hfb)) else $error("ie");
  a_soft_clr: assert property (soft_reset_i |=> ie == 8'h00) else $error("soft");
  a_err_sticky: assert property (se ##1 !reg_req_i && !soft_reset_i ##1 rd
    |=> (q & 8'h52) == 8'h52) else $error("sticky");
  a_rsvd_zero: assert property (rd |=> !q[5] && !q[3]) else $error("rsvd");
  a_clk_ready: assert property (oscillator_start_timer_done_i && phy_ready_i ##1 rd
    |=> q[0]) else $error("ready");
  a_rx_track: assert property (rd && $stable(receive_active_i)
    |=> q[2] == $past(receive_active_i)) else $error("rx");
  c_irq: cover property (!irq_n_o);
  c_clr: cover property (reg_req_i && reg_op_i == 2'h3);
  c_soft: cover property (soft_reset_i);
endmodule // esi_chk
bind esi_status_irq esi_chk esi_chk_inst (.*);

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clk_i = 0, rn = 0, sr = 0, be = 0, lc = 0, ra = 0, ta = 0, ok = 0, rq, sl, irq_n, pend;
  logic [1:0] op;
  logic [7:0] wd, q, fl = 8'h00, ie, ex, m;
  logic [31:0] s = 32'h48191a4f;
  int err_total = 0, n_compared = 0;
  always #4 clk_i = ~clk_i;
  esi_host esi_host_inst (.clk_i, .req_o(rq), .sel_o(sl), .op_o(op), .wd_o(wd));
  esi_status_irq esi_status_irq_inst (.clk_i, .reset_n_i(rn), .soft_reset_i(sr), .reg_req_i(rq),
    .reg_sel_i(sl), .reg_op_i(op), .reg_wdata_i(wd), .reg_rdata_o(q), .buffer_error_i(be),
    .late_collision_i(lc), .receive_active_i(ra), .transmit_abort_i(ta), .phy_ready_i(ok),
    .oscillator_start_timer_done_i(ok), .interrupt_flags_i(fl), .irq_n_o(irq_n),
    .irq_pending_o(pend), .interrupt_enable_o(ie));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; return x ^ (x << 5);
  endfunction
  task automatic chk(string n, logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end
  endtask
  task automatic rd(logic sl, logic [7:0] e, string n);
    esi_host_inst.cmd(sl, 2'h0, 8'h00);
    chk(n, e, q);
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin #20000; err_total++; finish_test; end
  initial begin
    repeat (5) @(posedge clk_i);
    #1 rn = 1;
    rd(1'b0, 8'h00, "timer counting");
    ok = 1;
    repeat (12) begin
      s = xs(s); ex = s[7:0] & 8'hfb;
      esi_host_inst.cmd(1'b1, 2'h1, s[7:0]);
      fl = s[15:8]; #1 m = fl & ex & 8'h7b;
      chk("enable out", ex, ie);
      chk("pin", {6'h0, |m, !(ex[7] && |m)}, {6'h0, pend, irq_n});
      rd(1'b1, ex, "enable");
    end
    fl = 8'h00; {be, lc, ta} = 3'h7;
    @(posedge clk_i) #1 {be, lc, ta} = 3'h0;
    rd(1'b0, 8'h53, "sticky");
    esi_host_inst.cmd(1'b0, 2'h3, 8'h52);
    ra = 1;
    rd(1'b0, 8'h05, "cleared");
    esi_host_inst.cmd(1'b1, 2'h2, 8'h80);
    ok = 0;
    @(posedge clk_i) #1 sr = 1;
    @(posedge clk_i) #1 sr = 0;
    rd(1'b1, 8'h00, "soft enable");
    rd(1'b0, 8'h05, "soft status");
    @(posedge clk_i) #1 rn = 0;
    @(posedge clk_i) #1 rn = 1;
    rd(1'b0, 8'h04, "power-on status");
    rd(1'b1, 8'h00, "power-on enable");
    finish_test;
  end
endmodule // tb
